// >>> design/rpc_cfg.svh
// Purpose: Constants for the redriver pin-control decode block
// Assumes: Three-level pins arrive already sliced into a 2-bit code
// Notes: Included by its bare name
`ifndef RPC_CFG_SVH
`define RPC_CFG_SVH
// Three-level pin codes
`define RPC_TRI_LOW 2'h0
`define RPC_TRI_HIGH 2'h1
`define RPC_TRI_MID 2'h2
// De-emphasis level codes
`define RPC_DE_0DB 3'h0
`define RPC_DE_3P5DB 3'h1
`define RPC_DE_6DB 3'h2
`define RPC_DE_6DB_ENH 3'h3
`define RPC_DE_9DB 3'h4
`define RPC_DE_12DB 3'h5
`define RPC_DE_9DB_HV 3'h6
`define RPC_DE_12DB_HV 3'h7
// Reset values
`define RPC_DE_RESET 3'h0
`define RPC_RATE_HIGH 1'h1
`define RPC_WIDE_RESET 4'hF
`endif

// >>> design/rpc_pkg.sv
// Purpose: Types for the redriver pin-control decode block
// Assumes: Constants come from rpc_cfg.svh
// Notes: Shared by the top and the side decoder
package rpc_pkg;
  typedef logic [1:0] rpc_tri_t; // Sliced three-level pin
  typedef logic [2:0] rpc_de_t; // De-emphasis level code
  typedef enum logic [1:0] {RPC_RATE_GEN1, RPC_RATE_GEN2, RPC_RATE_AUTO} rpc_rate_mode_t;
  typedef enum logic [1:0] {RPC_IDLE_FORCE, RPC_IDLE_PASS, RPC_IDLE_SQ_OFF} rpc_idle_mode_t;
endpackage

// >>> design/rpc_side_if.sv
// Purpose: Carrier between the top and one side decoder
// Assumes: One instance per side
// Notes: Pin-mode strap values in, decoded side settings out
`timescale 1ns/1ps
interface rpc_side_if;
  import rpc_pkg::*;
  logic pin_mode; // Straps own the settings
  rpc_tri_t dem_lo; // De-emphasis select low bit
  rpc_tri_t dem_hi; // De-emphasis select high bit
  rpc_de_t deemph; // Decoded level
  modport top (output pin_mode, output dem_lo, output dem_hi, input deemph);
  modport side (input pin_mode, input dem_lo, input dem_hi, output deemph);
endinterface

// >>> design/rpc_side_decode.sv
// Purpose: De-emphasis decode for one side, holding the last valid level
// Assumes: Strap codes synchronous to the clock
// Notes: All-mid pair is rejected and the previous level kept
`timescale 1ns/1ps
`include "rpc_cfg.svh"
module rpc_side_decode (
  input wire logic i_sys_clk,
  input wire logic i_rstn,
  rpc_side_if.side s
);
  import rpc_pkg::*;
  // ==========================================
  // State
  typedef struct packed {
    rpc_de_t deemph;
  } rpc_side_st_t;
  rpc_side_st_t st_r, st_nxt;
  logic valid; // Combination is usable

  // Pair decode; straps only honoured in pin mode
  always_comb begin
    st_nxt = st_r;
    valid = !(s.dem_hi == `RPC_TRI_MID && s.dem_lo == `RPC_TRI_MID); // [R19]
    if (s.pin_mode && valid) begin // [R2]
      case ({s.dem_hi, s.dem_lo}) // [R1]
        {`RPC_TRI_LOW, `RPC_TRI_LOW}: st_nxt.deemph = `RPC_DE_0DB;
        {`RPC_TRI_LOW, `RPC_TRI_HIGH}: st_nxt.deemph = `RPC_DE_3P5DB;
        {`RPC_TRI_HIGH, `RPC_TRI_LOW}: st_nxt.deemph = `RPC_DE_6DB;
        {`RPC_TRI_HIGH, `RPC_TRI_HIGH}: st_nxt.deemph = `RPC_DE_6DB_ENH;
        {`RPC_TRI_LOW, `RPC_TRI_MID}: st_nxt.deemph = `RPC_DE_9DB;
        {`RPC_TRI_HIGH, `RPC_TRI_MID}: st_nxt.deemph = `RPC_DE_12DB;
        {`RPC_TRI_MID, `RPC_TRI_LOW}: st_nxt.deemph = `RPC_DE_9DB_HV;
        {`RPC_TRI_MID, `RPC_TRI_HIGH}: st_nxt.deemph = `RPC_DE_12DB_HV;
        default: st_nxt.deemph = st_r.deemph; // Illegal code holds
      endcase
    end
  end

  // Register, constant reset
  always_ff @(posedge i_sys_clk or negedge i_rstn) begin
    if (!i_rstn) begin
      st_r.deemph <= `RPC_DE_RESET;
    end else begin
      st_r <= st_nxt; // [R18]
    end
  end
  assign s.deemph = st_r.deemph;

  // Checks
  property p_side_hold;
    @(posedge i_sys_clk) disable iff (!i_rstn)
      (s.dem_hi == `RPC_TRI_MID && s.dem_lo == `RPC_TRI_MID) |=> $stable(s.deemph);
  endproperty
  a_side_hold: assert property (p_side_hold) else $error("all-mid pair changed level"); // [R19]
  property p_side_smb;
    @(posedge i_sys_clk) disable iff (!i_rstn)
      !s.pin_mode |=> $stable(s.deemph);
  endproperty
  a_side_smb: assert property (p_side_smb) else $error("straps used in bus mode"); // [R2]
  property p_side_lowlow;
    @(posedge i_sys_clk) disable iff (!i_rstn)
      (s.pin_mode && s.dem_hi == `RPC_TRI_LOW && s.dem_lo == `RPC_TRI_LOW)
        |=> s.deemph == `RPC_DE_0DB;
  endproperty
  a_side_lowlow: assert property (p_side_lowlow) else $error("low-low not 0 dB"); // [R1]
endmodule

// >>> design/rpc_top.sv
// Purpose: Strap decode for a four-lane two-sided serial-link redriver
// Assumes: Three-level pins arrive pre-sliced as low, high or mid codes
// Notes: Register bank itself lives elsewhere; register values arrive as ports
`timescale 1ns/1ps
`include "rpc_cfg.svh"

// Overview of operation
// [R1] Per-side de-emphasis from its select pair
// [R2] De-emphasis straps used only in pin mode
// [R3] Pin mode applies one setting per side
// [R4] Bus mode: straps become address and bus lines
// [R5] Rate input sets de-emphasis pulse width
// [R6] Low forces gen1, high forces gen2
// [R7] Floating rate: detect after each idle exit
// [R8] Bus mode takes rate from registers
// [R9] Termination from side pin and enable
// [R10] Enable gates termination control both sides
// [R11] Cable absent input enters low power
// [R12] Idle pin: force, pass through, squelch off
// [R13] Three-level inputs decode low, high, mid
// [R14] Two-level inputs must be driven valid
// [R15] Undriven pulldown input reads as low
// [R16] Bus select gates register access
// [R17] Equalization straps only in pin mode
// [R18] Straps evaluated continuously, no reset latch
// [R19] All-mid de-emphasis pair rejected, level held
module rpc_top (
  input wire logic i_sys_clk,
  input wire logic i_rstn,
  input wire logic i_mgmt_bus_select, // High: register control
  input wire rpc_pkg::rpc_tri_t i_side_a_deemph_sel_lo,
  input wire rpc_pkg::rpc_tri_t i_side_a_deemph_sel_hi,
  input wire rpc_pkg::rpc_tri_t i_side_b_deemph_sel_lo,
  input wire rpc_pkg::rpc_tri_t i_side_b_deemph_sel_hi,
  input wire rpc_pkg::rpc_tri_t i_side_a_eq_sel_lo,
  input wire rpc_pkg::rpc_tri_t i_side_a_eq_sel_hi,
  input wire rpc_pkg::rpc_tri_t i_side_b_eq_sel_lo,
  input wire rpc_pkg::rpc_tri_t i_side_b_eq_sel_hi,
  input wire rpc_pkg::rpc_tri_t i_rate,
  input wire rpc_pkg::rpc_tri_t i_side_a_idle_control,
  input wire rpc_pkg::rpc_tri_t i_side_b_idle_control,
  input wire logic i_side_a_term_select,
  input wire logic i_side_b_term_select,
  input wire logic i_term_pin_control_enable,
  input wire logic i_cable_absent_powerdown,
  input wire logic i_idle_exit, // One-cycle pulse on idle exit
  input wire logic i_rate_detect_gen2, // Analog detector: gen2 seen
  input wire logic [3:0] i_reg_rate_gen2, // Per-lane register rate
  input wire rpc_pkg::rpc_de_t i_reg_deemph [4], // Per-lane register levels
  output logic o_reg_access_en,
  output logic [3:0] o_smb_addr,
  output logic o_smb_scl,
  output logic o_smb_sda_in,
  output rpc_pkg::rpc_tri_t o_side_a_eq_level,
  output rpc_pkg::rpc_tri_t o_side_a_eq_level_hi,
  output rpc_pkg::rpc_tri_t o_side_b_eq_level,
  output rpc_pkg::rpc_tri_t o_side_b_eq_level_hi,
  output rpc_pkg::rpc_de_t o_side_a_lane_deemph [4],
  output rpc_pkg::rpc_de_t o_side_b_lane_deemph [4],
  output logic [3:0] o_lane_wide_pulse, // High: gen1 wide pulse
  output rpc_pkg::rpc_rate_mode_t o_rate_mode,
  output logic o_side_a_term_50,
  output logic o_side_b_term_50,
  output logic o_low_power,
  output rpc_pkg::rpc_idle_mode_t o_side_a_idle_mode,
  output rpc_pkg::rpc_idle_mode_t o_side_b_idle_mode
);
  import rpc_pkg::*;

  // ==========================================
  // Registered state
  typedef struct packed {
    logic det_gen2; // Latched auto-detect result
    logic [3:0] wide;
    rpc_rate_mode_t rmode;
    logic term_a;
    logic term_b;
    logic lowp;
    rpc_idle_mode_t idle_a;
    rpc_idle_mode_t idle_b;
    logic [3:0] addr;
    logic scl;
    logic sda;
    rpc_tri_t eq_a_lo, eq_a_hi, eq_b_lo, eq_b_hi; // Equalization strap copies
  } rpc_top_st_t;
  rpc_top_st_t st_r, st_nxt;
  logic pin_mode;

  rpc_side_if side_a ();
  rpc_side_if side_b ();

  // ==========================================
  // Side de-emphasis decoders
  assign pin_mode = !i_mgmt_bus_select; // [R16]
  assign side_a.pin_mode = pin_mode;
  assign side_a.dem_lo = i_side_a_deemph_sel_lo;
  assign side_a.dem_hi = i_side_a_deemph_sel_hi;
  assign side_b.pin_mode = pin_mode;
  assign side_b.dem_lo = i_side_b_deemph_sel_lo;
  assign side_b.dem_hi = i_side_b_deemph_sel_hi;
  rpc_side_decode u_side_a (.i_sys_clk(i_sys_clk), .i_rstn(i_rstn), .s(side_a));
  rpc_side_decode u_side_b (.i_sys_clk(i_sys_clk), .i_rstn(i_rstn), .s(side_b));

  // Idle pin decode, three-level
  function automatic rpc_idle_mode_t idle_dec(input rpc_tri_t p);
    case (p) // [R13]
      `RPC_TRI_HIGH: idle_dec = RPC_IDLE_FORCE; // [R12]
      `RPC_TRI_LOW: idle_dec = RPC_IDLE_SQ_OFF;
      default: idle_dec = RPC_IDLE_PASS; // Mid passes idle through
    endcase
  endfunction

  // ==========================================
  // Next-state logic; straps sampled every cycle
  always_comb begin
    st_nxt = st_r;
    // Rate mode
    case (i_rate) // [R13]
      `RPC_TRI_LOW: st_nxt.rmode = RPC_RATE_GEN1; // [R6]
      `RPC_TRI_HIGH: st_nxt.rmode = RPC_RATE_GEN2;
      default: st_nxt.rmode = RPC_RATE_AUTO;
    endcase
    // Detector result taken only at an idle exit
    if (i_idle_exit) begin
      st_nxt.det_gen2 = i_rate_detect_gen2; // [R7]
    end
    for (int i = 0; i < 4; i++) begin
      if (!pin_mode) begin
        st_nxt.wide[i] = !i_reg_rate_gen2[i]; // [R8]
      end else begin
        case (st_nxt.rmode) // [R5] [R3]
          RPC_RATE_GEN1: st_nxt.wide[i] = 1'h1;
          RPC_RATE_GEN2: st_nxt.wide[i] = 1'h0;
          default: st_nxt.wide[i] = !st_r.det_gen2; // [R7]
        endcase
      end
    end
    // Termination; undriven pulldown pins read low
    st_nxt.term_a = i_term_pin_control_enable & i_side_a_term_select; // [R9] [R10] [R15]
    st_nxt.term_b = i_term_pin_control_enable & i_side_b_term_select; // [R9] [R10]
    st_nxt.lowp = i_cable_absent_powerdown; // [R11]
    st_nxt.idle_a = idle_dec(i_side_a_idle_control); // [R12]
    st_nxt.idle_b = idle_dec(i_side_b_idle_control);
    // Shared strap pins: address and bus lines or equalization
    if (!pin_mode) begin
      st_nxt.addr = {i_side_b_eq_sel_lo == `RPC_TRI_HIGH, i_side_b_eq_sel_hi == `RPC_TRI_HIGH,
                     i_side_b_deemph_sel_lo == `RPC_TRI_HIGH,
                     i_side_b_deemph_sel_hi == `RPC_TRI_HIGH}; // [R4] [R17]
      st_nxt.scl = i_side_a_deemph_sel_hi == `RPC_TRI_HIGH; // [R4]
      st_nxt.sda = i_side_a_deemph_sel_lo == `RPC_TRI_HIGH;
    end else begin
      st_nxt.eq_a_lo = i_side_a_eq_sel_lo; // [R17]
      st_nxt.eq_a_hi = i_side_a_eq_sel_hi;
      st_nxt.eq_b_lo = i_side_b_eq_sel_lo;
      st_nxt.eq_b_hi = i_side_b_eq_sel_hi;
    end
  end

  // State register; reset only defines values, no strap capture
  always_ff @(posedge i_sys_clk or negedge i_rstn) begin
    if (!i_rstn) begin
      st_r <= '0;
      st_r.rmode <= RPC_RATE_AUTO;
      st_r.idle_a <= RPC_IDLE_PASS;
      st_r.idle_b <= RPC_IDLE_PASS;
      st_r.wide <= `RPC_WIDE_RESET;
      st_r.eq_a_lo <= `RPC_TRI_MID;
      st_r.eq_a_hi <= `RPC_TRI_MID;
      st_r.eq_b_lo <= `RPC_TRI_MID;
      st_r.eq_b_hi <= `RPC_TRI_MID;
    end else begin
      st_r <= st_nxt; // [R18]
    end
  end

  // ==========================================
  // Outputs; lanes of a side share the strap level in pin mode
  genvar g;
  generate
    for (g = 0; g < 4; g++) begin : g_lane
      assign o_side_a_lane_deemph[g] = pin_mode ? side_a.deemph : i_reg_deemph[g]; // [R3]
      assign o_side_b_lane_deemph[g] = pin_mode ? side_b.deemph : i_reg_deemph[g];
    end
  endgenerate
  assign o_reg_access_en = i_mgmt_bus_select; // [R16]
  assign o_smb_addr = st_r.addr;
  assign o_smb_scl = st_r.scl;
  assign o_smb_sda_in = st_r.sda;
  assign o_side_a_eq_level = st_r.eq_a_lo;
  assign o_side_a_eq_level_hi = st_r.eq_a_hi;
  assign o_side_b_eq_level = st_r.eq_b_lo;
  assign o_side_b_eq_level_hi = st_r.eq_b_hi;
  assign o_lane_wide_pulse = st_r.wide;
  assign o_rate_mode = st_r.rmode;
  assign o_side_a_term_50 = st_r.term_a;
  assign o_side_b_term_50 = st_r.term_b;
  assign o_low_power = st_r.lowp;
  assign o_side_a_idle_mode = st_r.idle_a;
  assign o_side_b_idle_mode = st_r.idle_b;

  // ==========================================
  // Checks
  sequence s_gen1_req;
    pin_mode && i_rate == `RPC_TRI_LOW;
  endsequence
  property p_gen1;
    @(posedge i_sys_clk) disable iff (!i_rstn)
      s_gen1_req ##1 s_gen1_req |=> o_lane_wide_pulse == 4'hF;
  endproperty
  a_gen1: assert property (p_gen1) else $error("gen1 strap not wide pulse"); // [R6]
  property p_gen2;
    @(posedge i_sys_clk) disable iff (!i_rstn)
      pin_mode && i_rate == `RPC_TRI_HIGH |=> o_lane_wide_pulse == 4'h0;
  endproperty
  a_gen2: assert property (p_gen2) else $error("gen2 strap not narrow pulse"); // [R5]
  property p_auto;
    @(posedge i_sys_clk) disable iff (!i_rstn)
      pin_mode && i_rate == `RPC_TRI_MID ##1 pin_mode && i_rate == `RPC_TRI_MID
        |=> o_lane_wide_pulse == {4{!$past(st_r.det_gen2)}};
  endproperty
  a_auto: assert property (p_auto) else $error("auto rate not from detector"); // [R7]
  property p_regrate;
    @(posedge i_sys_clk) disable iff (!i_rstn)
      !pin_mode |=> o_lane_wide_pulse == ~$past(i_reg_rate_gen2);
  endproperty
  a_regrate: assert property (p_regrate) else $error("bus mode rate not from registers"); // [R8]
  property p_term;
    @(posedge i_sys_clk) disable iff (!i_rstn)
      !i_term_pin_control_enable |=> !o_side_a_term_50 && !o_side_b_term_50;
  endproperty
  a_term: assert property (p_term) else $error("termination set without enable"); // [R10]
  property p_terma;
    @(posedge i_sys_clk) disable iff (!i_rstn)
      i_term_pin_control_enable && i_side_a_term_select |=> o_side_a_term_50;
  endproperty
  a_terma: assert property (p_terma) else $error("side A termination missing"); // [R9]
  property p_lowp;
    @(posedge i_sys_clk) disable iff (!i_rstn)
      1'b1 |=> o_low_power == $past(i_cable_absent_powerdown);
  endproperty
  a_lowp: assert property (p_lowp) else $error("low power not tracking cable"); // [R11]
  property p_idle;
    @(posedge i_sys_clk) disable iff (!i_rstn)
      i_side_a_idle_control == `RPC_TRI_HIGH |=> o_side_a_idle_mode == RPC_IDLE_FORCE;
  endproperty
  a_idle: assert property (p_idle) else $error("idle high not forcing idle"); // [R12]
  property p_eqhold;
    @(posedge i_sys_clk) disable iff (!i_rstn)
      !pin_mode |=> $stable(o_side_a_eq_level) && $stable(o_side_b_eq_level);
  endproperty
  a_eqhold: assert property (p_eqhold) else $error("eq straps used in bus mode"); // [R17]
  property p_lanes;
    @(posedge i_sys_clk) disable iff (!i_rstn)
      pin_mode |-> o_side_a_lane_deemph[0] == o_side_a_lane_deemph[3];
  endproperty
  a_lanes: assert property (p_lanes) else $error("lanes of side A differ"); // [R3]
endmodule

// >>> test/rpc_strap_model.sv
// Purpose: Board strap and system pin model feeding the decode block
// Assumes: Bench calls the tasks just after a falling edge
// Notes: Three-level float reads mid; two-level float reads low
`timescale 1ns/1ps
module rpc_strap_model (
  output rpc_pkg::rpc_tri_t o_tri [11],
  output logic [4:0] o_bit
);
  import rpc_pkg::*;
  // ==========
  // Pin state
  rpc_tri_t tri_lvl [11] = '{default: 2'h2}; // All straps float
  logic [4:0] drv = 5'h00; // Driven flags
  logic [4:0] val = 5'h00; // Driven levels
  // Float biases to mid
  assign o_tri = tri_lvl;
  // Weak pulldown wins when undriven
  assign o_bit = drv & val;
  // ==========
  // Board actions
  task automatic set_tri(input int i, input rpc_tri_t c);
    tri_lvl[i] = c;
  endtask
  task automatic set_bit(input int i, input logic v);
    drv[i] = 1'b1;
    val[i] = v;
  endtask
  // Cable sense has no pulldown, so it never floats
  task automatic float_bit(input int i);
    if (i != 3) begin
      drv[i] = 1'b0;
    end
  endtask
endmodule

// >>> test/tb_redriver_pin_control_decode.sv
// Purpose: Self-checking bench for the pin-control decode block
// Assumes: Strap model drives pins after falling edges
// Notes: Registered outputs checked one edge after a change
`timescale 1ns/1ps
module tb_redriver_pin_control_decode;
  import rpc_pkg::*;
  // ==========
  // Signals
  logic i_sys_clk = 1'b0;
  logic i_rstn = 1'b0;
  logic i_idle_exit = 1'b0;
  logic i_rate_detect_gen2 = 1'b0;
  logic [3:0] i_reg_rate_gen2 = 4'h0;
  rpc_de_t i_reg_deemph [4] = '{3'h1, 3'h3, 3'h5, 3'h7}; // Distinct per lane
  rpc_tri_t tri_w [11];
  logic [4:0] bit_w;
  logic o_acc, o_scl, o_sda, o_ta, o_tb, o_lowp;
  logic [3:0] o_addr, o_wide;
  rpc_tri_t o_eq [4];
  rpc_de_t o_dea [4], o_deb [4];
  rpc_rate_mode_t o_rm;
  rpc_idle_mode_t o_ida, o_idb;
  int fail_count = 0;
  int comparisons = 0;
  int cycles = 0;
  int de_tab [9] = '{0, 1, 4, 2, 3, 5, 6, 7, 8}; // 8: pair rejected
  // ==========
  // Clock and hang guard
  always #2 i_sys_clk = ~i_sys_clk;
  always @(posedge i_sys_clk) begin
    cycles++;
    if (cycles == 2000) begin
      fail_count++;
      report_and_stop();
    end
  end
  // ==========
  // Instances
  rpc_strap_model pm (.o_tri(tri_w), .o_bit(bit_w));
  rpc_top uut (.i_sys_clk(i_sys_clk), .i_rstn(i_rstn), .i_mgmt_bus_select(bit_w[4]),
    .i_side_a_deemph_sel_lo(tri_w[0]), .i_side_a_deemph_sel_hi(tri_w[1]),
    .i_side_b_deemph_sel_lo(tri_w[2]), .i_side_b_deemph_sel_hi(tri_w[3]),
    .i_side_a_eq_sel_lo(tri_w[4]), .i_side_a_eq_sel_hi(tri_w[5]),
    .i_side_b_eq_sel_lo(tri_w[6]), .i_side_b_eq_sel_hi(tri_w[7]), .i_rate(tri_w[8]),
    .i_side_a_idle_control(tri_w[9]), .i_side_b_idle_control(tri_w[10]),
    .i_side_a_term_select(bit_w[0]), .i_side_b_term_select(bit_w[1]),
    .i_term_pin_control_enable(bit_w[2]), .i_cable_absent_powerdown(bit_w[3]),
    .i_idle_exit(i_idle_exit), .i_rate_detect_gen2(i_rate_detect_gen2),
    .i_reg_rate_gen2(i_reg_rate_gen2), .i_reg_deemph(i_reg_deemph), .o_reg_access_en(o_acc),
    .o_smb_addr(o_addr), .o_smb_scl(o_scl), .o_smb_sda_in(o_sda), .o_side_a_eq_level(o_eq[0]),
    .o_side_a_eq_level_hi(o_eq[1]), .o_side_b_eq_level(o_eq[2]), .o_side_b_eq_level_hi(o_eq[3]),
    .o_side_a_lane_deemph(o_dea), .o_side_b_lane_deemph(o_deb), .o_lane_wide_pulse(o_wide),
    .o_rate_mode(o_rm), .o_side_a_term_50(o_ta), .o_side_b_term_50(o_tb), .o_low_power(o_lowp),
    .o_side_a_idle_mode(o_ida), .o_side_b_idle_mode(o_idb));
  // ==========
  // Helpers
  task automatic report_and_stop();
    $display("Comparisons %0d, mismatches %0d", comparisons, fail_count);
    if (fail_count == 0 && comparisons > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask
  // Case inequality so an unknown never passes
  task automatic chk(input string name, input logic [3:0] exp, input logic [3:0] got);
    comparisons++;
    if (got !== exp) begin
      fail_count++;
      $display("MISMATCH %s expected %h seen %h", name, exp, got);
    end
  endtask
  task automatic step(input int n);
    repeat (n) @(posedge i_sys_clk);
    @(negedge i_sys_clk);
  endtask
  task automatic chk_lanes(input logic [3:0] ea, input logic [3:0] eb);
    for (int l = 0; l < 4; l++) begin
      chk("lane_a", ea, {1'b0, o_dea[l]});
      chk("lane_b", eb, {1'b0, o_deb[l]});
    end
  endtask
  // Reset values, pin mode assumed
  task automatic chk_reset();
    chk_lanes(4'h0, 4'h0);
    chk("wide", 4'hF, o_wide);
    chk("modes", 4'h9, {o_rm, o_ida});
    chk("eq_b", 4'hA, {o_eq[2], o_eq[3]});
    chk("flags", 4'h0, {o_ta, o_tb, o_lowp, o_scl});
    chk("addr", 4'h0, o_addr);
  endtask
  // ==========
  // Scenarios
  // Every pair code on both sides, rejected pair holds the last level
  task automatic t_deemph();
    logic [3:0] ha;
    logic [3:0] hb;
    ha = 4'h0;
    hb = 4'h0;
    for (int k = 0; k < 9; k++) begin
      pm.set_tri(1, 2'(k / 3));
      pm.set_tri(0, 2'(k % 3));
      pm.set_tri(3, 2'((8 - k) / 3));
      pm.set_tri(2, 2'((8 - k) % 3));
      step(1);
      if (de_tab[k] != 8) ha = 4'(de_tab[k]);
      if (de_tab[8 - k] != 8) hb = 4'(de_tab[8 - k]);
      chk_lanes(ha, hb);
    end
  endtask
  // Bus mode hands lanes to registers and straps to the address lines
  task automatic t_bus();
    pm.set_tri(4, 2'h1);
    pm.set_tri(5, 2'h0);
    step(1);
    chk("eq_a", 4'h4, {o_eq[0], o_eq[1]});
    pm.set_bit(4, 1'b1);
    i_reg_rate_gen2 = 4'h5;
    pm.set_tri(0, 2'h1);
    pm.set_tri(1, 2'h0);
    pm.set_tri(2, 2'h0);
    pm.set_tri(3, 2'h1);
    pm.set_tri(6, 2'h1);
    pm.set_tri(7, 2'h0);
    pm.set_tri(4, 2'h0);
    pm.set_tri(8, 2'h0);
    step(1);
    chk("access", 4'h1, {3'h0, o_acc});
    for (int l = 0; l < 4; l++) begin
      chk("reg_lane_a", {1'b0, i_reg_deemph[l]}, {1'b0, o_dea[l]});
      chk("reg_lane_b", {1'b0, i_reg_deemph[l]}, {1'b0, o_deb[l]});
    end
    chk("smb_addr", 4'h9, o_addr);
    chk("smb_lines", 4'h1, {2'h0, o_scl, o_sda});
    chk("eq_a", 4'h4, {o_eq[0], o_eq[1]});
    chk("eq_b", 4'hA, {o_eq[2], o_eq[3]});
    chk("wide", 4'hA, o_wide);
    pm.set_bit(4, 1'b0);
    pm.set_tri(2, 2'h1);
    step(1);
    chk("access", 4'h0, {3'h0, o_acc});
    chk("smb_addr", 4'h9, o_addr);
    chk_lanes(4'h1, 4'h3);
    chk("eq_a", 4'h0, {o_eq[0], o_eq[1]});
    chk("eq_b", 4'h4, {o_eq[2], o_eq[3]});
    chk("gen1", 4'h0, {2'h0, o_rm});
    chk("wide", 4'hF, o_wide);
  endtask
  // Forced gen2 rate, then detection only at idle exit
  task automatic t_rate();
    pm.set_tri(8, 2'h1);
    step(1);
    chk("gen2", 4'h1, {2'h0, o_rm});
    chk("wide", 4'h0, o_wide);
    pm.set_tri(8, 2'h2);
    i_rate_detect_gen2 = 1'b1;
    step(1);
    chk("auto", 4'h2, {2'h0, o_rm});
    chk("wide", 4'hF, o_wide);
    i_idle_exit = 1'b1;
    step(1);
    i_idle_exit = 1'b0;
    chk("wide", 4'hF, o_wide);
    step(1);
    chk("wide", 4'h0, o_wide);
    i_rate_detect_gen2 = 1'b0;
    step(2);
    chk("wide", 4'h0, o_wide);
    i_idle_exit = 1'b1;
    step(1);
    i_idle_exit = 1'b0;
    step(1);
    chk("wide", 4'hF, o_wide);
  endtask
  // Termination, power-down and idle modes
  task automatic t_misc();
    for (int k = 0; k < 8; k++) begin
      pm.set_bit(2, k[2]);
      pm.set_bit(0, k[0]);
      pm.set_bit(1, k[1]);
      step(1);
      chk("term", {2'h0, k[2] & k[0], k[2] & k[1]}, {2'h0, o_ta, o_tb});
    end
    pm.float_bit(2);
    step(1);
    chk("term", 4'h0, {2'h0, o_ta, o_tb});
    pm.set_bit(3, 1'b1);
    step(1);
    chk("lowp", 4'h1, {3'h0, o_lowp});
    pm.set_bit(3, 1'b0);
    step(1);
    chk("lowp", 4'h0, {3'h0, o_lowp});
    for (int c = 0; c < 3; c++) begin
      pm.set_tri(9, 2'(c));
      pm.set_tri(10, 2'(2 - c));
      step(1);
      chk("idle", {(c == 1) ? 2'h0 : (c == 0) ? 2'h2 : 2'h1,
                   (c == 1) ? 2'h0 : (c == 2) ? 2'h2 : 2'h1}, {o_ida, o_idb});
    end
  endtask
  // ==========
  // Main sequence, with a second reset in mid-run
  initial begin
    repeat (5) @(negedge i_sys_clk);
    chk_reset();
    i_rstn = 1'b1;
    t_deemph();
    t_bus();
    t_rate();
    t_misc();
    i_rstn = 1'b0;
    #1;
    chk_reset();
    step(1);
    i_rstn = 1'b1;
    step(1);
    chk_lanes(4'h1, 4'h3);
    report_and_stop();
  end
endmodule
